// ### ram_parity_error_reporter_tb_top.sv
/*
 * self-checking bench for the parity error reporter: apb tasks, detect
 * stimulus and a latching controller model. assumes zero or more wait states.
 */
`default_nettype none

module ram_parity_error_reporter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCPU = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, err, clr = 1'b0, off_bad = 1'b0;
   logic [NCPU-1:0][7:0] det = '0, vec, seen_vec;
   logic [7:0][NCPU-1:0] dt;
   logic [15:0] tag = 16'h0000, hi_cycles;
   logic [NCPU-1:0] snoop, seen_snoop;
   logic [1:0][7:0] off_vec;
   logic [1:0] off_snoop;
   int n_errors = 0, samples_checked = 0;

   always #4 pclk = ~pclk;
   // per-cpu stimulus vectors regrouped into per-array detect buses
   always_comb
      for (int c = 0; c < NCPU; c++)
         for (int b = 0; b < 8; b++)
            dt[b][c] = det[c][b];

   rper_top #(.NCPU(NCPU), .PARITY_EN(1'b1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .btb_fail_det(dt[7]), .global_history_fail_det(dt[6]),
      .itag_fail_det(dt[5]), .idata_fail_det(dt[4]), .tlb_fail_det(dt[3]), .douter_fail_det(dt[2]),
      .dtag_fail_det(dt[1]), .ddata_fail_det(dt[0]), .snoop_tag_fail_det(tag),
      .ram_error_pulse_vector(vec), .snoop_tag_error_pulse(snoop), .irq(irq));
   // build without parity shares the detects; its pulses must stay low
   rper_top #(.NCPU(2), .PARITY_EN(1'b0)) dut_off (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
      .pready(), .pslverr(), .btb_fail_det(dt[7][1:0]), .global_history_fail_det(dt[6][1:0]),
      .itag_fail_det(dt[5][1:0]), .idata_fail_det(dt[4][1:0]), .tlb_fail_det(dt[3][1:0]),
      .douter_fail_det(dt[2][1:0]), .dtag_fail_det(dt[1][1:0]), .ddata_fail_det(dt[0][1:0]),
      .snoop_tag_fail_det(tag[7:0]), .ram_error_pulse_vector(off_vec), .snoop_tag_error_pulse(off_snoop),
      .irq());
   rper_sic_model #(.NCPU(NCPU)) sic (.pclk(pclk), .presetn(presetn), .clr(clr), .vec(vec),
      .snoop(snoop), .seen_vec(seen_vec), .seen_snoop(seen_snoop), .hi_cycles(hi_cycles));

   // sticky flag for any pulse from the parity-less build
   always @(posedge pclk)
      if (off_vec !== '0 || off_snoop !== '0)
         off_bad <= 1'b1;

   // ****************************************
   // tasks
   // ****************************************
   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t register got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pulse(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t pulse got %h exp %h", $time, got, exp);
      end
   endtask : chk_pulse

   // request held until pready is sampled high; answer taken at that edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16)
      begin
         n_errors++;
         summarize();
      end
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      chk_reg(rd, exp);
      chk_reg(32'(err), 32'(experr));
   endtask : rdchk

   // detects for hold+1 cycles; pulse must last one cycle, model must see it once
   task automatic fire(input logic [31:0] d, input logic [15:0] t, input logic [3:0] s, input int hold);
      @(posedge pclk);
      det <= d;
      tag <= t;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      #1;
      chk_pulse(vec, d);
      chk_pulse(32'(snoop), 32'(s));
      repeat (hold) @(posedge pclk);
      det <= '0;
      tag <= 16'h0000;
      #1;
      chk_pulse(vec, 32'h0);
      chk_pulse(32'(snoop), 32'h0);
      repeat (2) @(posedge pclk);
      #1;
      chk_pulse(seen_vec, d);
      chk_pulse(32'(seen_snoop), 32'(s));
      chk_pulse(32'(hi_cycles), 32'($countones(d) + $countones(s)));
   endtask : fire

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(rper_pkg::OFF_STATUS, 32'h0, 1'b0);
      rdchk(rper_pkg::OFF_MASK, 32'h0, 1'b0);
      rdchk(rper_pkg::OFF_HIST, 32'h0, 1'b0);
      rdchk(rper_pkg::OFF_CONFIG, 32'h0000_0104, 1'b0);
      apb(1'b1, rper_pkg::OFF_CONFIG, 32'h0);
      rdchk(rper_pkg::OFF_CONFIG, 32'h0000_0104, 1'b0);
      rdchk(12'h010, 32'h0, 1'b1);
      rdchk(12'h002, 32'h0, 1'b1);
      // every array of every processor alone
      for (int c = 0; c < NCPU; c++)
         for (int b = 0; b < 8; b++)
            fire(32'h1 << (c * 8 + b), 16'h0, 4'h0, 1);
      rdchk(rper_pkg::OFF_STATUS, 32'h0ff, 1'b0);
      fire(32'h8000_0001, 16'h0, 4'h0, 5);
      fire('1, '1, 4'hf, 1);
      for (int i = 0; i < 16; i++)
         fire(32'h0, 16'h1 << i, 4'h1 << (i / 4), 1);
      fire(32'h0, 16'h0300, 4'h4, 3);
      rdchk(rper_pkg::OFF_STATUS, 32'h1ff, 1'b0);
      apb(1'b1, rper_pkg::OFF_STATUS, 32'h1ff);
      rdchk(rper_pkg::OFF_STATUS, 32'h0, 1'b0);
      // interrupt raised, cleared, then masked out
      apb(1'b1, rper_pkg::OFF_MASK, 32'h002);
      rdchk(rper_pkg::OFF_MASK, 32'h002, 1'b0);
      // unmapped alias of the mask offset: refused and ignored
      apb(1'b1, 12'h104, 32'h1ff);
      chk_reg(32'(err), 32'h1);
      rdchk(rper_pkg::OFF_MASK, 32'h002, 1'b0);
      fire(32'h0200_0000, 16'h0, 4'h0, 1);
      chk_reg(32'(irq), 32'h1);
      apb(1'b1, rper_pkg::OFF_STATUS, 32'h002);
      rdchk(rper_pkg::OFF_STATUS, 32'h0, 1'b0);
      chk_reg(32'(irq), 32'h0);
      fire(32'h0000_0080, 16'h0, 4'h0, 1);
      chk_reg(32'(irq), 32'h0);
      rdchk(rper_pkg::OFF_STATUS, 32'h080, 1'b0);
      // history: a held detect counts once
      apb(1'b1, rper_pkg::OFF_HIST, 32'h0);
      fire(32'h0002_2000, 16'h0, 4'h0, 1);
      fire(32'h0000_0800, 16'h0, 4'h0, 4);
      rdchk(rper_pkg::OFF_HIST, 32'h0001_0002, 1'b0);
      chk_pulse(32'(off_bad), 32'h0);
      summarize();
   end
endmodule : ram_parity_error_reporter_tb_top

`default_nettype wire

// ### rper_evt_if.sv
/*
 * carrier between the reporter top and its sticky status block.
 * assumes both ends run on pclk; all fields are plain levels or strobes.
 */
`default_nettype none

interface rper_evt_if;
   logic [8:0] event_set; // one-cycle event per status bit
   logic [8:0] w1c_clr; // one-cycle clear strobes
   logic mask_we;
   logic [8:0] mask_wdata;
   logic [8:0] status;
   logic [8:0] mask;

   modport ctl (output event_set, output w1c_clr, output mask_we, output mask_wdata,
      input status, input mask);
   modport stat (input event_set, input w1c_clr, input mask_we, input mask_wdata,
      output status, output mask);
endinterface : rper_evt_if

`default_nettype wire

// ### rper_irq.sv
/*
 * sticky event status, write-one-to-clear, with a mask and one level
 * interrupt. assumes strobes arrive through the stat modport on pclk.
 */
`default_nettype none

module rper_irq (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // events and register access
   rper_evt_if.stat evt,
   // interrupt
   output logic irq
);
   typedef struct packed {
      logic [8:0] status;
      logic [8:0] mask;
   } rper_irq_st_t;

   rper_irq_st_t st_r;
   rper_irq_st_t st_nxt;

   // set wins over clear so an event in the clear cycle is kept
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.status = (st_r.status & ~evt.w1c_clr) | evt.event_set;
      if (evt.mask_we)
         st_nxt.mask = evt.mask_wdata;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r.status <= rper_pkg::RST_STATUS;
         st_r.mask <= rper_pkg::RST_MASK;
      end
      else
         st_r <= st_nxt;
   end

   assign evt.status = st_r.status;
   assign evt.mask = st_r.mask;
   assign irq = |(st_r.status & st_r.mask); // mask bit 1 lets the event through
endmodule : rper_irq

`default_nettype wire

// ### rper_pkg.sv
/*
 * constants shared by the parity error reporter: register map, field
 * positions, reset values and the array-to-bit mapping of each vector.
 * assumes a 32-bit apb slave port with byte addresses and one clock.
 */
`default_nettype none

package rper_pkg;
   // ****************************************
   // cluster shape
   // ****************************************
   localparam int MAX_CPU = 4;
   localparam int TAG_PER_CPU = 4;
   localparam int VEC_W = 8;
   localparam int EVT_W = 9;
   localparam int ADDR_W = 12;

   // ****************************************
   // bit positions inside ram_error_pulse_vector
   // ****************************************
   localparam int BIT_BTB = 7;
   localparam int BIT_GHIST = 6;
   localparam int BIT_ITAG = 5;
   localparam int BIT_IDATA = 4;
   localparam int BIT_TLB = 3;
   localparam int BIT_DOUTER = 2;
   localparam int BIT_DTAG = 1;
   localparam int BIT_DDATA = 0;
   localparam int BIT_SNOOP = 8; // status only: any snoop tag failure

   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [11:0] OFF_STATUS = 12'h000;
   localparam logic [11:0] OFF_MASK = 12'h004;
   localparam logic [11:0] OFF_HIST = 12'h008;
   localparam logic [11:0] OFF_CONFIG = 12'h00c;
   localparam logic [8:0] RST_STATUS = 9'h000;
   localparam logic [8:0] RST_MASK = 9'h000;
   localparam logic [15:0] RST_COUNT = 16'h0000;

   // history register fields
   localparam int HIST_CNT_LSB = 0;
   localparam int HIST_CPU_LSB = 16;
   // config register fields
   localparam int CFG_NCPU_LSB = 0;
   localparam int CFG_PAR_BIT = 8;
endpackage : rper_pkg

`default_nettype wire

// ### rper_pulse.sv
/*
 * turns raw failure detect lines into one-cycle pulses on their rising edge.
 * assumes detect lines come from logic on pclk, so no synchroniser.
 */
`default_nettype none

module rper_pulse #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // detect in, pulse out
   input wire logic [W-1:0] det,
   output logic [W-1:0] pulse
);
   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] pulse;
   } rper_pulse_st_t;

   rper_pulse_st_t st_r;
   rper_pulse_st_t st_nxt;

   // edge detect: a held detect line gives one pulse, not a level
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.prev = det;
      st_nxt.pulse = det & ~st_r.prev;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign pulse = st_r.pulse;
endmodule : rper_pulse

`default_nettype wire

// ### rper_sic_model.sv
/*
 * behavioural system integrity controller: latches every pulse bit.
 * assumes pulses come on pclk and the bench clears it between events.
 */
`default_nettype none

module rper_sic_model #(
   parameter int NCPU = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pulses in, clear from the bench
   input wire logic clr,
   input wire logic [NCPU-1:0][7:0] vec,
   input wire logic [NCPU-1:0] snoop,
   // latched view
   output var logic [NCPU-1:0][7:0] seen_vec,
   output var logic [NCPU-1:0] seen_snoop,
   output var logic [15:0] hi_cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   // sample on every edge: a one-cycle pulse is lost otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn || clr)
      begin
         seen_vec <= '0;
         seen_snoop <= '0;
         hi_cycles <= 16'h0000;
      end
      else
      begin
         seen_vec <= seen_vec | vec;
         seen_snoop <= seen_snoop | snoop;
         hi_cycles <= hi_cycles + 16'($countones({vec, snoop})); // bit-cycles, so one per pulse
      end
   end
endmodule : rper_sic_model

`default_nettype wire

// ### rper_top.sv
/*
 * parity error reporter for a processor cluster: per-processor pulse vectors
 * for the ram arrays, a per-processor snoop tag pulse, and an apb view with
 * sticky status, mask, interrupt and a failure history.
 * assumes detect inputs are produced on pclk by the array parity checkers and
 * that the collecting controller samples the pulses on every pclk edge.
 */
//
// Behaviour
// - pulse outputs exist only when parity is built in; otherwise held zero.
// - one pulse vector per processor, count set by the processor parameter.
// - each vector is eight bits; one means parity failure, zero none.
// - bits 7..4 are branch target, global history, instr tag, instr data.
// - bits 3..0 are main tlb, data outer, data tag, data data.
// - each vector bit pulses exactly one clock per detected failure.
// - one snoop tag output per processor, the or of its tag ram failures.
// - each snoop tag bit pulses for exactly one clock per rise of the or of its tag ram detects.
`default_nettype none

module rper_top #(
   parameter int NCPU = 4,
   parameter bit PARITY_EN = 1'b1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // raw parity detects from the arrays, one bit per processor
   input wire logic [NCPU-1:0] btb_fail_det,
   input wire logic [NCPU-1:0] global_history_fail_det,
   input wire logic [NCPU-1:0] itag_fail_det,
   input wire logic [NCPU-1:0] idata_fail_det,
   input wire logic [NCPU-1:0] tlb_fail_det,
   input wire logic [NCPU-1:0] douter_fail_det,
   input wire logic [NCPU-1:0] dtag_fail_det,
   input wire logic [NCPU-1:0] ddata_fail_det,
   // raw detects from the snoop control unit tag rams
   input wire logic [NCPU*rper_pkg::TAG_PER_CPU-1:0] snoop_tag_fail_det,
   // pulses to the system integrity controller
   output logic [NCPU-1:0][7:0] ram_error_pulse_vector,
   output logic [NCPU-1:0] snoop_tag_error_pulse,
   // interrupt
   output logic irq
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [31:0] prdata;
      logic pslverr;
      logic [1:0] last_cpu;
      logic [15:0] fail_cnt;
   } rper_top_st_t;

   rper_top_st_t st_r;
   rper_top_st_t st_nxt;

   logic [NCPU-1:0][7:0] raw_vec;
   logic [NCPU-1:0] snoop_raw;
   logic [NCPU-1:0][7:0] vec_pulse;
   logic [NCPU-1:0] snoop_pulse;
   logic [8:0] evt_any;
   logic setup_ph;
   logic wr_acc;
   logic hit;

   rper_evt_if evt ();

   // ****************************************
   // array mapping and per-processor pulse shaping
   // ****************************************
   genvar c;
   generate
      for (c = 0; c < NCPU; c++)
      begin : g_cpu
         // fixed array-to-bit order of each vector
         assign raw_vec[c][rper_pkg::BIT_BTB] = btb_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_GHIST] = global_history_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_ITAG] = itag_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_IDATA] = idata_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_TLB] = tlb_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_DOUTER] = douter_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_DTAG] = dtag_fail_det[c];
         assign raw_vec[c][rper_pkg::BIT_DDATA] = ddata_fail_det[c];
         // all tag rams of one processor fold into one line
         assign snoop_raw[c] = |snoop_tag_fail_det[c*rper_pkg::TAG_PER_CPU +: rper_pkg::TAG_PER_CPU];

         if (PARITY_EN)
         begin : g_par
            // one shaper per processor keeps the vectors independent
            rper_pulse #(.W(9)) u_pulse (
               .pclk(pclk),
               .presetn(presetn),
               .det({snoop_raw[c], raw_vec[c]}),
               .pulse({snoop_pulse[c], vec_pulse[c]})
            );
         end
         else
         begin : g_nopar
            // no parity build: nothing is reported
            assign vec_pulse[c] = 8'h00;
            assign snoop_pulse[c] = 1'b0;
         end

         // ------------------------------------
         // checks per processor
         // ------------------------------------
         chk_vec_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
            (ram_error_pulse_vector[c] != 8'h00) |=> ((ram_error_pulse_vector[c] & $past(ram_error_pulse_vector[c])) == 8'h00))
            else $error("ram error pulse held longer than one cycle");
         chk_snoop_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
            snoop_tag_error_pulse[c] |=> !snoop_tag_error_pulse[c])
            else $error("snoop tag pulse held longer than one cycle");
         chk_snoop_or_tags: assert property (@(posedge pclk) disable iff (!presetn)
            (PARITY_EN && !$past(snoop_raw[c]) && (snoop_tag_fail_det[c*rper_pkg::TAG_PER_CPU +: rper_pkg::TAG_PER_CPU] != '0))
            |=> snoop_tag_error_pulse[c])
            else $error("snoop tag failure not reported on its processor");
         chk_upper_map: assert property (@(posedge pclk) disable iff (!presetn)
            (PARITY_EN && $rose(btb_fail_det[c]) && !global_history_fail_det[c])
            |=> ram_error_pulse_vector[c][7] && !ram_error_pulse_vector[c][6])
            else $error("branch target failure not on bit 7");
         chk_lower_map: assert property (@(posedge pclk) disable iff (!presetn)
            (PARITY_EN && $rose(ddata_fail_det[c]) && !tlb_fail_det[c])
            |=> ram_error_pulse_vector[c][0] && !ram_error_pulse_vector[c][3])
            else $error("data data failure not on bit 0");
         chk_no_fail_quiet: assert property (@(posedge pclk) disable iff (!presetn)
            (raw_vec[c] == 8'h00) |=> (ram_error_pulse_vector[c] == 8'h00))
            else $error("pulse without a parity failure");
         chk_vec_per_cpu: assert property (@(posedge pclk) disable iff (!presetn)
            (PARITY_EN && $past(presetn)) |->
            (ram_error_pulse_vector[c] == ($past(raw_vec[c]) & ~$past(raw_vec[c], 2))))
            else $error("processor vector does not follow its own arrays");
         chk_no_parity_zero: assert property (@(posedge pclk) disable iff (!presetn)
            !PARITY_EN |-> ##2 (ram_error_pulse_vector[c] == 8'h00) && !snoop_tag_error_pulse[c])
            else $error("outputs active in a build without parity");
      end
   endgenerate

   // outputs come straight from the shaper flops
   assign ram_error_pulse_vector = vec_pulse;
   assign snoop_tag_error_pulse = snoop_pulse;

   // ****************************************
   // summary events for the status register
   // ****************************************
   always_comb
   begin
      evt_any = 9'h000;
      for (int i = 0; i < NCPU; i++)
      begin
         evt_any[7:0] = evt_any[7:0] | vec_pulse[i];
         evt_any[rper_pkg::BIT_SNOOP] = evt_any[rper_pkg::BIT_SNOOP] | snoop_pulse[i];
      end
   end

   // ****************************************
   // apb decode
   // ****************************************
   // zero wait states: data is fetched in the setup cycle
   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign hit = (paddr == rper_pkg::OFF_STATUS) || (paddr == rper_pkg::OFF_MASK) ||
      (paddr == rper_pkg::OFF_HIST) || (paddr == rper_pkg::OFF_CONFIG);

   // strobes to the sticky block
   assign evt.event_set = evt_any;
   assign evt.w1c_clr = (wr_acc && paddr == rper_pkg::OFF_STATUS) ? pwdata[8:0] : 9'h000;
   assign evt.mask_we = wr_acc && (paddr == rper_pkg::OFF_MASK);
   assign evt.mask_wdata = pwdata[8:0];

   // ****************************************
   // read data, error flag and failure history
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      // history: count cycles with any failure, saturating so it never wraps
      if ((evt_any != 9'h000) && (st_r.fail_cnt != 16'hffff))
         st_nxt.fail_cnt = st_r.fail_cnt + 16'h0001;
      // highest numbered processor that failed this cycle
      for (int i = 0; i < NCPU; i++)
      begin
         if ((vec_pulse[i] != 8'h00) || snoop_pulse[i])
            st_nxt.last_cpu = 2'(i);
      end
      // writing the history register clears the counter
      if (wr_acc && paddr == rper_pkg::OFF_HIST)
         st_nxt.fail_cnt = rper_pkg::RST_COUNT;
      if (setup_ph)
      begin
         st_nxt.prdata = 32'h0000_0000;
         st_nxt.pslverr = !hit;
         if (!pwrite)
         begin
            unique case (1'b1)
               paddr == rper_pkg::OFF_STATUS:
                  st_nxt.prdata[8:0] = evt.status;
               paddr == rper_pkg::OFF_MASK:
                  st_nxt.prdata[8:0] = evt.mask;
               paddr == rper_pkg::OFF_HIST:
               begin
                  st_nxt.prdata[rper_pkg::HIST_CNT_LSB +: 16] = st_r.fail_cnt;
                  st_nxt.prdata[rper_pkg::HIST_CPU_LSB +: 2] = st_r.last_cpu;
               end
               paddr == rper_pkg::OFF_CONFIG:
               begin
                  st_nxt.prdata[rper_pkg::CFG_NCPU_LSB +: 3] = 3'(NCPU);
                  st_nxt.prdata[rper_pkg::CFG_PAR_BIT] = PARITY_EN;
               end
               default:
                  st_nxt.prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r.prdata <= 32'h0000_0000;
         st_r.pslverr <= 1'b0;
         st_r.last_cpu <= 2'h0;
         st_r.fail_cnt <= rper_pkg::RST_COUNT;
      end
      else
         st_r <= st_nxt;
   end

   assign prdata = st_r.prdata;
   assign pslverr = st_r.pslverr && psel && penable;
   assign pready = 1'b1;

   // ****************************************
   // bus and status checks
   // ****************************************
   // an event landing in a clear cycle must still be seen by software
   chk_status_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.event_set != 9'h000) |=> ((evt.status & $past(evt.event_set)) == $past(evt.event_set)))
      else $error("status event lost");
   // write one to clear, with no new event in the same cycle
   chk_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && (paddr == rper_pkg::OFF_STATUS) && (evt.event_set == 9'h000))
      |=> ((evt.status & $past(pwdata[8:0])) == 9'h000))
      else $error("status bit not cleared by a one");
   // mask takes the written word one cycle later
   chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      evt.mask_we |=> (evt.mask == $past(evt.mask_wdata)))
      else $error("mask write not taken");
   // an enabled event raises the interrupt on the next cycle
   chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (((evt.event_set & evt.mask) != 9'h000) && !evt.mask_we) |=> irq)
      else $error("enabled event did not raise the interrupt");
   // unmapped offsets answer with an error, mapped ones never
   chk_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !hit) |-> pslverr)
      else $error("unmapped access without error");
   chk_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && hit) |-> !pslverr)
      else $error("mapped access flagged as error");
   // read data must not move once the access phase has been taken
   chk_rdata_held: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable) |=> $stable(prdata))
      else $error("read data changed after the access phase");
   // any write to the history register restarts the count
   chk_hist_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && (paddr == rper_pkg::OFF_HIST)) |=> (st_r.fail_cnt == rper_pkg::RST_COUNT))
      else $error("history count not cleared");
   // one step per failing cycle, however many bits pulse in it
   chk_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
      ((evt_any != 9'h000) && (st_r.fail_cnt != 16'hffff) && !(wr_acc && (paddr == rper_pkg::OFF_HIST)))
      |=> (st_r.fail_cnt == ($past(st_r.fail_cnt) + 16'h0001)))
      else $error("history count did not step once");
   // snoop tag pulses show up in the summary bit
   chk_snoop_status: assert property (@(posedge pclk) disable iff (!presetn)
      (|snoop_tag_error_pulse) |=> evt.status[rper_pkg::BIT_SNOOP])
      else $error("snoop tag pulse missing from status");
   // a build without parity never records a failure
   chk_no_parity_status: assert property (@(posedge pclk) disable iff (!presetn)
      !PARITY_EN |-> (evt.status == rper_pkg::RST_STATUS))
      else $error("status set in a build without parity");

   // ****************************************
   // sticky status, mask and interrupt
   // ****************************************
   rper_irq u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .evt(evt),
      .irq(irq)
   );
endmodule : rper_top

`default_nettype wire
